// ---- logic/rtctr_ctrl.sv ----
`timescale 1ns/1ps
module rtctr_ctrl #(
  parameter int HALT_CYCLES = rtctr_pkg::HALT_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       osc_clk_in,
  input  wire logic       alarm_a_match,
  input  wire logic       alarm_b_match,
  input  wire logic       minute_tick,
  input  wire logic       hour_tick,
  input  wire logic       month_tick,
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_we,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            second_tick,
  output logic            irq_pin_a_out,
  output logic            irq_pin_a_oe,
  output logic            irq_pin_b_out,
  output logic            irq_pin_b_oe
);

  // ========================================================
  // State
  // ========================================================
  localparam logic [15:0] HALT_LIM = 16'(HALT_CYCLES - 1);

  typedef struct packed {
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_prev;
    logic [15:0] halt_cnt;
    logic        halt;
    logic [7:0]  ctl_e;
    logic [6:0]  trim;
    logic        xsel;
    logic        clk_n;
    logic        test;
    logic        flag_a;
    logic        flag_b;
    logic        flag_p;
    logic        hit_a_prev;
    logic        hit_b_prev;
    logic        pin_a_oe;
    logic        pin_b_oe;
    logic        pin_a_out;
    logic        pin_b_out;
    logic        sec_out;
    logic [7:0]  rdata;
  } rtctr_state_t;

  rtctr_state_t s;
  rtctr_state_t next_s;
  logic         osc_rise;
  logic         osc_edge;
  logic         halt_ev;
  logic         wr_e;
  logic         wr_f;
  logic         wr_t;
  logic         hit_a;
  logic         hit_b;
  logic         t_sec;
  logic         t_low1;
  logic         t_low2;
  logic [2:0]   pmode;

  // Hardware set beats a same-cycle software clear
  function automatic logic set_wins(input logic cur,
                                    input logic set,
                                    input logic wr,
                                    input logic wbit);
    return set | (cur & ~(wr & ~wbit));
  endfunction

  // ========================================================
  // Trimmed second divider
  // ========================================================
  rtctr_trim u_trim (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .osc_rise       (osc_rise),
    .trim_value     (s.trim),
    .crystal_select (s.xsel),
    .sec_tick       (t_sec),
    .low_1hz        (t_low1),
    .low_2hz        (t_low2)
  );

  // ========================================================
  // Next state
  // ========================================================
  always_comb begin
    next_s = s;
    // Oscillator pin crosses into ref_clk before use
    next_s.osc_s1   = osc_clk_in;
    next_s.osc_s2   = s.osc_s1;
    next_s.osc_prev = s.osc_s2;
    osc_rise = s.osc_s2 & ~s.osc_prev;
    osc_edge = s.osc_s2 ^ s.osc_prev;

    // Watchdog on oscillator edges; saturates while stopped
    next_s.halt_cnt = osc_edge ? 16'h0000 :
                      (s.halt_cnt == HALT_LIM) ? s.halt_cnt :
                      s.halt_cnt + 16'h0001;
    halt_ev = !osc_edge && (s.halt_cnt == HALT_LIM);

    wr_e = reg_we && (reg_addr == rtctr_pkg::ADDR_INT_CTL);
    wr_f = reg_we && (reg_addr == rtctr_pkg::ADDR_FLAG_CTL);
    wr_t = reg_we && (reg_addr == rtctr_pkg::ADDR_TRIM);

    if (wr_e) begin
      next_s.ctl_e = reg_wdata & rtctr_pkg::E_WMASK;
    end
    if (wr_t) begin
      next_s.trim = reg_wdata[6:0];
    end
    if (wr_f) begin
      next_s.clk_n = reg_wdata[rtctr_pkg::F_CLKN];
      next_s.xsel  = reg_wdata[rtctr_pkg::F_XSEL];
      next_s.test  = reg_wdata[rtctr_pkg::F_TEST];
    end

    // Only a zero write clears; a one write is ignored
    next_s.halt = set_wins(s.halt, halt_ev, wr_f,
                           reg_wdata[rtctr_pkg::F_HALT]);
    if (next_s.halt) begin
      next_s.ctl_e = 8'h00;
      next_s.trim  = 7'h00;
      next_s.xsel  = 1'b0;
      next_s.clk_n = 1'b0;
      next_s.test  = 1'b0;
    end

    // Alarms share one scheme, rising edge of enabled match
    hit_a = next_s.ctl_e[rtctr_pkg::E_EN_A] & alarm_a_match;
    hit_b = next_s.ctl_e[rtctr_pkg::E_EN_B] & alarm_b_match;
    next_s.hit_a_prev = hit_a;
    next_s.hit_b_prev = hit_b;
    next_s.flag_a = next_s.ctl_e[rtctr_pkg::E_EN_A] &
                    set_wins(s.flag_a, hit_a & ~s.hit_a_prev, wr_f,
                             reg_wdata[rtctr_pkg::F_FLAG_A]);
    next_s.flag_b = next_s.ctl_e[rtctr_pkg::E_EN_B] &
                    set_wins(s.flag_b, hit_b & ~s.hit_b_prev, wr_f,
                             reg_wdata[rtctr_pkg::F_FLAG_B]);

    // Periodic source; pulse modes follow divider phase
    pmode = next_s.ctl_e[2:0];
    case (pmode)
      rtctr_pkg::PER_OFF:   next_s.flag_p = 1'b0;
      rtctr_pkg::PER_HOLD:  next_s.flag_p = 1'b1;
      rtctr_pkg::PER_2HZ:   next_s.flag_p = t_low2;
      rtctr_pkg::PER_1HZ:   next_s.flag_p = t_low1;
      rtctr_pkg::PER_SEC:   next_s.flag_p =
        set_wins(s.flag_p, t_sec, wr_f, reg_wdata[rtctr_pkg::F_FLAG_P]);
      rtctr_pkg::PER_MIN:   next_s.flag_p =
        set_wins(s.flag_p, minute_tick, wr_f,
                 reg_wdata[rtctr_pkg::F_FLAG_P]);
      rtctr_pkg::PER_HOUR:  next_s.flag_p =
        set_wins(s.flag_p, hour_tick, wr_f,
                 reg_wdata[rtctr_pkg::F_FLAG_P]);
      rtctr_pkg::PER_MONTH: next_s.flag_p =
        set_wins(s.flag_p, month_tick, wr_f,
                 reg_wdata[rtctr_pkg::F_FLAG_P]);
      default:              next_s.flag_p = 1'b0;
    endcase

    // Pin enables are wired-OR of routed sources
    next_s.pin_a_oe = next_s.flag_a |
      (~next_s.ctl_e[rtctr_pkg::E_ROUTE_LO] & next_s.flag_b) |
      (~next_s.ctl_e[rtctr_pkg::E_ROUTE_HI] & next_s.flag_p);
    // Clock term uses the raw synchronised level, not the trim
    next_s.pin_b_oe =
      (next_s.ctl_e[rtctr_pkg::E_ROUTE_LO] & next_s.flag_b) |
      (next_s.ctl_e[rtctr_pkg::E_ROUTE_HI] & next_s.flag_p) |
      (~next_s.clk_n & ~s.osc_s2);
    next_s.pin_a_out = 1'b0;
    next_s.pin_b_out = 1'b0;
    next_s.sec_out   = t_sec;

    // Read data lags the address by one edge
    case (reg_addr)
      rtctr_pkg::ADDR_INT_CTL:  next_s.rdata = s.ctl_e;
      rtctr_pkg::ADDR_FLAG_CTL: next_s.rdata =
        {s.test, 1'b0, s.xsel, s.halt, s.clk_n,
         s.flag_p, s.flag_a, s.flag_b};
      rtctr_pkg::ADDR_TRIM:     next_s.rdata = {1'b0, s.trim};
      default:                  next_s.rdata = 8'h00;
    endcase
  end

  // ========================================================
  // Registers
  // ========================================================
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s      <= '0;
      s.halt <= rtctr_pkg::HALT_RESET;
      // Synchroniser resets low, so pin B opens in the low phase
      s.pin_b_oe <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata     = s.rdata;
  assign second_tick   = s.sec_out;
  assign irq_pin_a_out = s.pin_a_out;
  assign irq_pin_a_oe  = s.pin_a_oe;
  assign irq_pin_b_out = s.pin_b_out;
  assign irq_pin_b_oe  = s.pin_b_oe;

  // ========================================================
  // Checks
  // ========================================================
  halt_forces_zero_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    s.halt |-> (s.ctl_e == 8'h00 && s.trim == 7'h00 && !s.xsel &&
                !s.clk_n && !s.test))
    else $error("control bits not cleared while halted");

  halt_sticky_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    (s.halt && !(wr_f && !reg_wdata[rtctr_pkg::F_HALT])) |=> s.halt)
    else $error("halt flag dropped without a zero write");

  halt_sense_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    (s.halt_cnt == HALT_LIM && !osc_edge) |=> s.halt)
    else $error("oscillator stop did not set halt flag");

  pin_a_or_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    irq_pin_a_oe == (s.flag_a |
      (!s.ctl_e[rtctr_pkg::E_ROUTE_LO] && s.flag_b) |
      (!s.ctl_e[rtctr_pkg::E_ROUTE_HI] && s.flag_p)))
    else $error("pin A is not the OR of its sources");

  pin_b_route_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    irq_pin_b_oe == ((s.ctl_e[rtctr_pkg::E_ROUTE_LO] && s.flag_b) |
      (s.ctl_e[rtctr_pkg::E_ROUTE_HI] && s.flag_p) |
      (!s.clk_n && !s.osc_prev)))
    else $error("pin B routing wrong");

  never_high_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    !irq_pin_a_out && !irq_pin_b_out)
    else $error("interrupt pin driven high");

  alarm_set_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    (s.ctl_e[rtctr_pkg::E_EN_A] && !next_s.halt &&
     next_s.ctl_e[rtctr_pkg::E_EN_A] && alarm_a_match &&
     !s.hit_a_prev) |=> (s.flag_a && irq_pin_a_oe))
    else $error("enabled alarm match did not set flag");

  alarm_release_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    !s.ctl_e[rtctr_pkg::E_EN_B] |-> !s.flag_b)
    else $error("alarm flag stands with enable off");

  flag_clear_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    (wr_f && !reg_wdata[rtctr_pkg::F_FLAG_A] &&
     !(hit_a && !s.hit_a_prev)) |=> !s.flag_a)
    else $error("alarm flag survived a zero write");

  periodic_hold_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    (s.ctl_e[2:0] == rtctr_pkg::PER_HOLD) |-> s.flag_p)
    else $error("held-low periodic mode not asserted");

  periodic_off_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    (s.ctl_e[2:0] == rtctr_pkg::PER_OFF) |-> !s.flag_p)
    else $error("periodic flag set while periodic is off");

  flag_read_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    (reg_addr == rtctr_pkg::ADDR_FLAG_CTL) |=>
      reg_rdata[2:0] == $past({s.flag_p, s.flag_a, s.flag_b}))
    else $error("flag read does not show source state");

  halt_pins_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    (s.halt && !s.flag_a && !s.flag_b && !s.flag_p) |->
      (!irq_pin_a_oe && irq_pin_b_oe == !s.osc_prev))
    else $error("halted pin state wrong");

endmodule // rtctr_ctrl

// ---- pkg/rtctr_pkg.sv ----
// ==========================================================
// Trim, halt sense and interrupt routing constants
// ==========================================================
package rtctr_pkg;

  // ========================================================
  // Clock and timing
  // ========================================================
  localparam int          CLK_HZ        = 20_000_000;
  localparam int          HALT_TIME_US  = 1000;
  localparam int          HALT_CYCLES   = (CLK_HZ / 1_000_000) * HALT_TIME_US;
  localparam int          HALT_CNT_W    = 16;
  localparam int          TRIM_PERIOD_S = 20;
  localparam logic [15:0] OSC_PULSES_A  = 16'h8000;
  localparam logic [15:0] OSC_PULSES_B  = 16'h7D00;
  localparam int          TRIM_STEP     = 2;

  // ========================================================
  // Register offsets
  // ========================================================
  localparam logic [3:0]  ADDR_TRIM     = 4'h7;
  localparam logic [3:0]  ADDR_INT_CTL  = 4'hE;
  localparam logic [3:0]  ADDR_FLAG_CTL = 4'hF;

  // ========================================================
  // Interrupt control fields
  // ========================================================
  localparam int          E_EN_A        = 7;
  localparam int          E_EN_B        = 6;
  localparam int          E_ROUTE_HI    = 5;
  localparam int          E_ROUTE_LO    = 4;
  localparam logic [7:0]  E_WMASK       = 8'hF7;

  // ========================================================
  // Flag and clock control fields
  // ========================================================
  localparam int          F_TEST        = 7;
  localparam int          F_XSEL        = 5;
  localparam int          F_HALT        = 4;
  localparam int          F_CLKN        = 3;
  localparam int          F_FLAG_P      = 2;
  localparam int          F_FLAG_A      = 1;
  localparam int          F_FLAG_B      = 0;

  // ========================================================
  // Reset values and periodic modes
  // ========================================================
  localparam logic        HALT_RESET    = 1'b1;
  localparam logic [2:0]  PER_OFF       = 3'h0;
  localparam logic [2:0]  PER_HOLD      = 3'h1;
  localparam logic [2:0]  PER_2HZ       = 3'h2;
  localparam logic [2:0]  PER_1HZ       = 3'h3;
  localparam logic [2:0]  PER_SEC       = 3'h4;
  localparam logic [2:0]  PER_MIN       = 3'h5;
  localparam logic [2:0]  PER_HOUR      = 3'h6;
  localparam logic [2:0]  PER_MONTH     = 3'h7;

endpackage

// ---- logic/rtctr_trim.sv ----
`timescale 1ns/1ps
module rtctr_trim (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       osc_rise,
  input  wire logic [6:0] trim_value,
  input  wire logic       crystal_select,
  output logic            sec_tick,
  output logic            low_1hz,
  output logic            low_2hz
);

  // ========================================================
  // Trim arithmetic
  // ========================================================
  localparam logic [8:0] TRIM_STEP_W = 9'(rtctr_pkg::TRIM_STEP);
  localparam logic [4:0] LAST_IDX    = 5'(rtctr_pkg::TRIM_PERIOD_S - 1);

  // Positive result lengthens the trimmed second
  function automatic logic signed [8:0] trim_delta(input logic [6:0] code);
    logic [7:0] mag;
    mag = 8'h80 - {1'b0, code};
    if (!code[6]) begin
      if (code <= 7'h01) return 9'sh000;
      return 9'(TRIM_STEP_W * (code - 7'h01));
    end
    if (mag >= 8'h3F) return 9'sh000;
    return -9'(TRIM_STEP_W * mag);
  endfunction

  typedef struct packed {
    logic [15:0] cnt;
    logic [4:0]  idx;
    logic        sec;
    logic        l1;
    logic        l2;
  } rtctr_trim_state_t;

  rtctr_trim_state_t s;
  rtctr_trim_state_t next_s;
  logic [15:0]       base;
  logic [15:0]       len;
  logic [15:0]       half;
  logic [15:0]       quarter;
  logic signed [8:0] delta;

  // ========================================================
  // Second divider
  // ========================================================
  always_comb begin
    next_s  = s;
    base    = crystal_select ? rtctr_pkg::OSC_PULSES_B
                             : rtctr_pkg::OSC_PULSES_A;
    delta   = trim_delta(trim_value);
    // Only one second in each trim period is stretched or cut
    len     = (s.idx == LAST_IDX) ? base + 16'(delta) : base;
    half    = len >> 1;
    quarter = len >> 2;
    next_s.sec = 1'b0;
    if (osc_rise) begin
      if (s.cnt >= len - 16'h0001) begin
        next_s.cnt = 16'h0000;
        next_s.sec = 1'b1;
        next_s.idx = (s.idx == LAST_IDX) ? 5'h00 : s.idx + 5'h01;
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
      end
    end
    next_s.l1 = next_s.cnt < half;
    next_s.l2 = (next_s.cnt < quarter) ||
                (next_s.cnt >= half && next_s.cnt < half + quarter);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sec_tick = s.sec;
  assign low_1hz  = s.l1;
  assign low_2hz  = s.l2;

  // ========================================================
  // Checks
  // ========================================================
  slow_codes_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!trim_value[6] && trim_value >= 7'h02) |-> delta > 9'sh000)
    else $error("positive trim code does not lengthen second");

  fast_codes_a: assert property (@(posedge ref_clk) disable iff (rst)
    (trim_value[6] && trim_value >= 7'h42) |-> delta < 9'sh000)
    else $error("negative trim code does not shorten second");

  fast_step_a: assert property (@(posedge ref_clk) disable iff (rst)
    (trim_value == 7'h7F) |-> delta == -9'sh002)
    else $error("smallest speed-up step wrong");

  slow_step_a: assert property (@(posedge ref_clk) disable iff (rst)
    (trim_value == 7'h02) |-> delta == 9'sh002)
    else $error("smallest slow-down step wrong");

  no_corr_a: assert property (@(posedge ref_clk) disable iff (rst)
    (trim_value inside {7'h00, 7'h01, 7'h40, 7'h41}) |-> len == base)
    else $error("neutral trim code changed second length");

  plain_second_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s.idx != LAST_IDX) |-> len == base)
    else $error("second trimmed outside last slot of period");

endmodule // rtctr_trim

// ---- dv/rtctr_host.sv ----
`timescale 1ns/1ps
// ==========================================================
// Host side of the pins: pull-ups and clock watch
// ==========================================================
module rtctr_host (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        a_out,
  input  wire logic        a_oe,
  input  wire logic        b_out,
  input  wire logic        b_oe,
  output logic             irq_pin_a,
  output logic             irq_pin_b,
  output logic      [15:0] b_toggles
);
  logic b_last;

  // Released pins float to the pull-up; a high drive shows as a wrong level
  assign irq_pin_a = a_oe ? a_out : 1'b1;
  assign irq_pin_b = b_oe ? b_out : 1'b1;

  // Edge count on pin B, so the bench can tell a running clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      b_toggles <= 16'h0000;
      b_last    <= 1'b1;
    end else begin
      b_last <= irq_pin_b;
      if (b_last != irq_pin_b) begin
        b_toggles <= b_toggles + 16'h0001;
      end
    end
  end
endmodule // rtctr_host

// ---- dv/test_rtc_trim_halt_sense_irq_routing.sv ----
`timescale 1ns/1ps
module test_rtc_trim_halt_sense_irq_routing;
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] val;
  } rtctr_exp_t;

  // ========================================================
  // Signals
  // ========================================================
  logic        ref_clk, rst, osc, osc_run, match_a, match_b, reg_we, chk;
  logic        sec_seen;
  logic [2:0]  ticks;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, seen, v;
  logic        second_tick, a_out, a_oe, b_out, b_oe, irq_pin_a, irq_pin_b;
  logic [15:0] b_toggles, tog_mark;
  rtctr_exp_t  exp_q[$];
  rtctr_exp_t  cur;
  int          mismatches, cmp_count, cycles, seed, i, m;

  localparam logic [3:0] AT = rtctr_pkg::ADDR_TRIM;
  localparam logic [3:0] AE = rtctr_pkg::ADDR_INT_CTL;
  localparam logic [3:0] AF = rtctr_pkg::ADDR_FLAG_CTL;

  // ========================================================
  // Design and host model
  // ========================================================
  // Short halt window keeps the stopped-oscillator test brief
  rtctr_ctrl #(.HALT_CYCLES(50)) u_dut (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .osc_clk_in   (osc),
    .alarm_a_match(match_a),
    .alarm_b_match(match_b),
    .minute_tick  (ticks[0]),
    .hour_tick    (ticks[1]),
    .month_tick   (ticks[2]),
    .reg_addr     (reg_addr),
    .reg_we       (reg_we),
    .reg_wdata    (reg_wdata),
    .reg_rdata    (reg_rdata),
    .second_tick  (second_tick),
    .irq_pin_a_out(a_out),
    .irq_pin_a_oe (a_oe),
    .irq_pin_b_out(b_out),
    .irq_pin_b_oe (b_oe)
  );

  rtctr_host u_host (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .a_out    (a_out),
    .a_oe     (a_oe),
    .b_out    (b_out),
    .b_oe     (b_oe),
    .irq_pin_a(irq_pin_a),
    .irq_pin_b(irq_pin_b),
    .b_toggles(b_toggles)
  );

  // ========================================================
  // Clocks; oscillator far faster than real, unrelated phase
  // ========================================================
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    osc = 1'b0;
    forever begin
      #1007;
      if (osc_run) osc = ~osc;
    end
  end

  // ========================================================
  // Driver tasks
  // ========================================================
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_we    <= 1'b1;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask

  task automatic note(input logic [1:0] k, input logic [7:0] e);
    exp_q.push_back('{kind: k, val: e});
    @(posedge ref_clk);
    chk <= 1'b1;
    @(posedge ref_clk);
    chk <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    repeat (2) @(posedge ref_clk);
    note(2'h0, e);
  endtask

  task automatic pins(input logic [1:0] e);
    repeat (3) @(posedge ref_clk);
    note(2'h1, {6'h00, e});
  endtask

  task automatic clk_chk(input logic e);
    tog_mark = b_toggles;
    repeat (100) @(posedge ref_clk);
    note(2'h2, {7'h00, e});
  endtask

  task automatic pulse(input logic [2:0] t);
    @(posedge ref_clk);
    ticks <= t;
    @(posedge ref_clk);
    ticks <= 3'h0;
  endtask

  task automatic conclude();
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ========================================================
  // Watcher: oldest note against what the outputs show
  // ========================================================
  always @(posedge ref_clk) begin
    if (chk === 1'b1) begin
      cur = exp_q.pop_front();
      case (cur.kind)
        2'h0:    seen = reg_rdata;
        2'h1:    seen = {6'h00, irq_pin_b, irq_pin_a};
        2'h2:    seen = {7'h00, (b_toggles - tog_mark) > 16'h0004};
        default: seen = {6'h00, sec_seen, irq_pin_a};
      endcase
      cmp_count++;
      if (seen !== cur.val) begin
        mismatches++;
        $display("BAD %s exp %h got %h", cur.kind == 2'h0 ? "reg_rdata" :
                 cur.kind == 2'h1 ? "irq_pins" :
                 cur.kind == 2'h2 ? "pin_b_clock" : "pin_a_second",
                 cur.val, seen);
      end
    end
  end

  // A hang is cut short far above the normal run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  // A whole second needs far more oscillator pulses than a run gives
  always @(posedge ref_clk) begin
    sec_seen <= rst ? 1'b0 : (sec_seen | (second_tick === 1'b1));
  end

  // ========================================================
  // Scenarios
  // ========================================================
  initial begin
    rst = 1'b1;
    osc_run = 1'b1;
    {match_a, match_b, reg_we, chk, ticks} = 7'h00;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    tog_mark = 16'h0000;
    seed = 40;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(AF, 8'h10);
    rd(AE, 8'h00);
    note(2'h3, 8'h01);
    clk_chk(1'b1);
    wr(AE, 8'hFF);
    rd(AE, 8'h00);
    wr(AT, 8'h3F);
    rd(AT, 8'h00);
    wr(AF, 8'h08);
    rd(AF, 8'h08);
    pins(2'h3);
    clk_chk(1'b0);
    for (i = 0; i < 9; i++) begin
      v = (i == 0) ? 8'h02 : (i == 1) ? 8'h7F : (i == 2) ? 8'h41 :
          (i == 3) ? 8'h42 : 8'($random(seed));
      wr(AT, v);
      rd(AT, v & 8'h7F);
    end
    // Trim back to neutral before the busy register traffic
    wr(AT, 8'h00);
    wr(AE, 8'hFF);
    rd(AE, 8'hF7);
    wr(AE, 8'h80);
    match_a <= 1'b1;
    pins(2'h2);
    rd(AF, 8'h0A);
    wr(AF, 8'h08);
    pins(2'h3);
    wr(AE, 8'h00);
    match_a <= 1'b0;
    for (i = 0; i < 4; i++) begin
      wr(AE, 8'h40 | 8'(i << 4));
      match_b <= 1'b1;
      pins(i[0] ? 2'h1 : 2'h2);
      rd(AF, 8'h09);
      wr(AE, 8'h00);
      pins(2'h3);
      match_b <= 1'b0;
    end
    wr(AE, 8'hC0);
    {match_a, match_b} <= 2'h3;
    pins(2'h2);
    wr(AF, 8'h09);
    rd(AF, 8'h09);
    pins(2'h2);
    wr(AE, 8'h00);
    {match_a, match_b} <= 2'h0;
    pins(2'h3);
    wr(AE, 8'h01);
    pins(2'h2);
    rd(AF, 8'h0C);
    wr(AE, 8'h21);
    pins(2'h1);
    for (m = 2; m < 4; m++) begin
      wr(AE, 8'(m));
      pins(2'h2);
    end
    wr(AE, 8'h00);
    pins(2'h3);
    for (m = 5; m < 8; m++) begin
      wr(AE, 8'(m));
      pulse(3'h1 << ((m - 4) % 3));
      pins(2'h3);
      pulse(3'h1 << (m - 5));
      pins(2'h2);
      wr(AF, 8'h08);
      pins(2'h3);
    end
    wr(AE, 8'hB7);
    wr(AT, 8'h55);
    wr(AF, 8'h28);
    rd(AF, 8'h28);
    // Oscillator stands still long past the halt window
    osc_run = 1'b0;
    repeat (100) @(posedge ref_clk);
    rd(AF, 8'h10);
    rd(AE, 8'h00);
    rd(AT, 8'h00);
    osc_run = 1'b1;
    repeat (100) @(posedge ref_clk);
    rd(AF, 8'h10);
    clk_chk(1'b1);
    note(2'h3, 8'h01);
    conclude();
  end
endmodule // test_rtc_trim_halt_sense_irq_routing
